//--- hw/wmp_regs.sv
// Purpose: wake-up flags, wake enables, 1 ms prescaler and calibrated slow clock trim
// Assumes: clock_i is the die link clock; wake sources and oscillator are asynchronous
// Notes: every transfer takes one wait state; registers decoded in two address pages
//
// Functional notes
// - writing one clears a wake flag; writing zero leaves it.
// - flag bit 7 records an amp-hour threshold wake-up.
// - flag bit 6 records a current threshold wake-up.
// - flag bit 5 records a calibration request wake-up.
// - flag bit 4 records a LIN wake-up.
// - flag bits 3 to 0 record wake-ups from pins 3 to 0.
// - the ms prescaler is 16 bits, written by halfword or word; byte writes are ignored.
// - the prescaler divides the link clock into fast and slow derived clocks.
// - each high enable bit gates one wake source.
// - low enable bit 7 gates lifetime overflow; bits 6..0 read zero; reset zero.
// - ready reads zero while calibration sync runs after reset or change.
// - ready reads one once the calibrated clock is synchronised.
// - trim shows the 13-bit calibrated divider; bits 14, 13 read zero.
// - the calibrated divider divides the low-power oscillator into the calibrated clock.
// - after reset the calibrated divider holds 0x0200 until first sync.
// - trim bytes are read only; writes change nothing.
// - registers answer in the blocking and the non-blocking page.
// - divider factor divides by 1, 2, 4 or 8; change restarts sync.
//
// Chosen here: the AHB-Lite register port.
`default_nettype none

module wmp_regs (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output var logic [31:0] hrdata_o,
  output var logic hreadyout_o,
  output var logic hresp_o,
  input wire logic [7:0] wake_source_i,
  input wire logic lifetime_overflow_i,
  input wire logic lp_osc_i,
  output var logic wake_request_o,
  output var logic derived_fast_clock_o,
  output var logic derived_slow_clock_o,
  output var logic calibrated_low_freq_clock_o,
  output var logic calib_sync_ready_o,
  output var logic irq_o
);

  // ==========================================================================
  // bus slave state
  logic dphase_reg;
  logic hit_reg;
  logic wr_reg;
  logic [5:0] idx_reg;
  logic [2:0] size_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;

  wire logic page_hit = (haddr_i[31:8] == wmp_pkg::BASE_BLOCK_PAGE)
                      | (haddr_i[31:8] == wmp_pkg::BASE_NONBLK_PAGE);
  wire logic addr_take = hsel_i & htrans_i[1] & hready_i;
  wire logic wr_go = dphase_reg & hit_reg & wr_reg;
  wire logic rd_go = dphase_reg & ~wr_reg;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dphase_reg <= 1'b0;
      hit_reg <= 1'b0;
      wr_reg <= 1'b0;
      idx_reg <= 6'h00;
      size_reg <= 3'h0;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else if (addr_take) begin
      dphase_reg <= 1'b1;
      hit_reg <= page_hit & (haddr_i[1:0] == 2'h0);
      wr_reg <= hwrite_i;
      idx_reg <= haddr_i[7:2];
      size_reg <= hsize_i;
      hreadyout_reg <= 1'b0;
    end else begin
      dphase_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // register write strobes
  wire logic wr_stat = wr_go & (idx_reg == wmp_pkg::IDX_STAT_LO);
  wire logic wr_ms_divider_value = wr_go & (idx_reg == wmp_pkg::IDX_MS_DIVIDER_VALUE)
                      & (size_reg != wmp_pkg::HSIZE_BYTE);
  wire logic wr_wen_hi = wr_go & (idx_reg == wmp_pkg::IDX_WEN_HI);
  wire logic wr_wen_lo = wr_go & (idx_reg == wmp_pkg::IDX_WEN_LO);
  wire logic wr_ctrl = wr_go & (idx_reg == wmp_pkg::IDX_CTRL);
  wire logic wr_irq_stat = wr_go & (idx_reg == wmp_pkg::IDX_IRQ_STAT);
  wire logic wr_irq_mask = wr_go & (idx_reg == wmp_pkg::IDX_IRQ_MASK);

  // ==========================================================================
  // input synchronisers and edge detect
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic [9:0] sync3_reg;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_reg <= 10'h000;
      sync2_reg <= 10'h000;
      sync3_reg <= 10'h000;
    end else begin
      sync1_reg <= {lp_osc_i, lifetime_overflow_i, wake_source_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  wire logic [9:0] rise = sync2_reg & ~sync3_reg;
  wire logic [7:0] src_rise = rise[7:0];
  wire logic ltc_rise = rise[8];
  wire logic lp_edge = rise[9];

  // ==========================================================================
  // wake enables and flags
  logic [7:0] stat_reg;
  logic [7:0] wen_hi_reg;
  logic [7:0] wen_lo_reg;
  logic wake_request_reg;

  wire logic [7:0] flag_set = src_rise & wen_hi_reg;
  wire logic [7:0] flag_clr = wr_stat ? hwdata_i[7:0] : 8'h00;
  wire logic [7:0] stat_next = (stat_reg & ~flag_clr) | flag_set;
  wire logic ltc_wake = ltc_rise & wen_lo_reg[wmp_pkg::WEN_LO_LTC_POS];
  wire logic wake_request_next = (|flag_set) | ltc_wake;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      stat_reg <= wmp_pkg::STAT_LO_RST;
      wen_hi_reg <= wmp_pkg::WEN_HI_RST;
      wen_lo_reg <= wmp_pkg::WEN_LO_RST;
      wake_request_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      wake_request_reg <= wake_request_next;
      if (wr_wen_hi) begin
        wen_hi_reg <= hwdata_i[7:0];
      end
      if (wr_wen_lo) begin
        wen_lo_reg <= {hwdata_i[7], 7'h00};
      end
    end
  end

  // ==========================================================================
  // 1 ms prescaler and derived clocks
  logic [15:0] ms_divider_value_reg;
  logic [1:0] pf_reg;
  logic [15:0] ms_cnt_reg;
  logic [2:0] fct_cnt_reg;
  logic fast_reg;
  logic slow_reg;

  wire logic pf_change = wr_ctrl & (hwdata_i[1:0] != pf_reg);
  wire logic ms_last = (ms_divider_value_reg == 16'h0000)
                     | (ms_cnt_reg >= ms_divider_value_reg - 16'h0001);
  wire logic [2:0] pf_mask = {pf_reg == 2'h3, pf_reg[1], pf_reg != 2'h0};
  wire logic slow_last = (fct_cnt_reg & pf_mask) == pf_mask;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ms_divider_value_reg <= wmp_pkg::MS_DIVIDER_VALUE_RST;
      pf_reg <= wmp_pkg::PF_RST;
      ms_cnt_reg <= 16'h0000;
      fct_cnt_reg <= 3'h0;
      fast_reg <= 1'b0;
      slow_reg <= 1'b0;
    end else begin
      if (wr_ms_divider_value) begin
        ms_divider_value_reg <= hwdata_i[15:0];
      end
      if (wr_ctrl) begin
        pf_reg <= hwdata_i[1:0];
      end
      ms_cnt_reg <= ms_last ? 16'h0000 : ms_cnt_reg + 16'h0001;
      fast_reg <= ms_last;
      slow_reg <= ms_last & slow_last;
      if (ms_last) begin
        fct_cnt_reg <= slow_last ? 3'h0 : fct_cnt_reg + 3'h1;
      end
    end
  end

  // ==========================================================================
  // calibration of the low-power oscillator
  wmp_pkg::wmp_sync_type state_reg;
  wmp_pkg::wmp_sync_type state_next;
  logic [12:0] calib_reg;
  logic [12:0] meas_cnt_reg;
  logic [12:0] lp_cnt_reg;
  logic ready_reg;
  logic cal_tick_reg;

  wire logic restart = wr_ms_divider_value | pf_change;
  wire logic meas_end = (state_reg == wmp_pkg::WMP_SYNC_MEASURE) & ms_last & ~restart;
  // the edge in the closing cycle belongs to the window, so a full fast period is counted
  wire logic [12:0] meas_sum = meas_cnt_reg
                             + {12'h000, lp_edge & (meas_cnt_reg != wmp_pkg::CALIB_MAX)};
  wire logic [12:0] meas_val = (meas_sum == 13'h0000) ? 13'h0001 : meas_sum;
  wire logic lp_last = lp_edge & (lp_cnt_reg >= calib_reg - 13'h0001);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wmp_pkg::WMP_SYNC_START: begin
        if (ms_last) begin
          state_next = wmp_pkg::WMP_SYNC_MEASURE;
        end
      end
      wmp_pkg::WMP_SYNC_MEASURE: begin
        if (ms_last) begin
          state_next = wmp_pkg::WMP_SYNC_DONE;
        end
      end
      wmp_pkg::WMP_SYNC_DONE: begin
        state_next = wmp_pkg::WMP_SYNC_DONE;
      end
      default: begin
        state_next = wmp_pkg::WMP_SYNC_START;
      end
    endcase
    if (restart) begin
      state_next = wmp_pkg::WMP_SYNC_START;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= wmp_pkg::WMP_SYNC_START;
      calib_reg <= wmp_pkg::CALIB_RST;
      meas_cnt_reg <= 13'h0000;
      lp_cnt_reg <= 13'h0000;
      ready_reg <= 1'b0;
      cal_tick_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == wmp_pkg::WMP_SYNC_DONE);
      if (state_reg != wmp_pkg::WMP_SYNC_MEASURE) begin
        meas_cnt_reg <= 13'h0000;
      end else if (lp_edge && meas_cnt_reg != wmp_pkg::CALIB_MAX) begin
        meas_cnt_reg <= meas_cnt_reg + 13'h0001;
      end
      if (meas_end) begin
        calib_reg <= meas_val;
      end
      if (lp_last) begin
        lp_cnt_reg <= 13'h0000;
      end else if (lp_edge) begin
        lp_cnt_reg <= lp_cnt_reg + 13'h0001;
      end
      cal_tick_reg <= lp_last;
    end
  end

  // ==========================================================================
  // interrupt status and mask
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic irq_reg;

  wire logic [1:0] irq_set = {meas_end, |flag_set};
  wire logic [1:0] irq_clr = wr_irq_stat ? hwdata_i[1:0] : 2'h0;
  wire logic [1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_stat_reg <= wmp_pkg::IRQ_RST;
      irq_mask_reg <= wmp_pkg::IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_next & (wr_irq_mask ? hwdata_i[1:0] : irq_mask_reg));
      if (wr_irq_mask) begin
        irq_mask_reg <= hwdata_i[1:0];
      end
    end
  end

  // ==========================================================================
  // read data
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (idx_reg)
      wmp_pkg::IDX_STAT_LO: rd_word[7:0] = stat_reg;
      wmp_pkg::IDX_MS_DIVIDER_VALUE: rd_word[15:0] = ms_divider_value_reg;
      wmp_pkg::IDX_WEN_HI: rd_word[7:0] = wen_hi_reg;
      wmp_pkg::IDX_WEN_LO: rd_word[7:0] = wen_lo_reg;
      wmp_pkg::IDX_TRIM_HI: rd_word[7:0] = {ready_reg, 2'h0, calib_reg[12:8]};
      wmp_pkg::IDX_TRIM_LO: rd_word[7:0] = calib_reg[7:0];
      wmp_pkg::IDX_CTRL: rd_word[1:0] = pf_reg;
      wmp_pkg::IDX_IRQ_STAT: rd_word[1:0] = irq_stat_reg;
      wmp_pkg::IDX_IRQ_MASK: rd_word[1:0] = irq_mask_reg;
      default: rd_word = 32'h0000_0000;
    endcase
    if (!hit_reg) begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata_reg <= rd_word;
    end
  end

  // ==========================================================================
  // outputs
  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;
  assign wake_request_o = wake_request_reg;
  assign derived_fast_clock_o = fast_reg;
  assign derived_slow_clock_o = slow_reg;
  assign calibrated_low_freq_clock_o = cal_tick_reg;
  assign calib_sync_ready_o = ready_reg;
  assign irq_o = irq_reg;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  sequence s_clear_write(int b);
    wr_stat && hwdata_i[b];
  endsequence

  a_w1c_clear: assert property (
    s_clear_write(0) and !flag_set[0] |=> !stat_reg[0])
    else $error("wake flag not cleared by write of one");
  a_zero_keeps: assert property (
    wr_stat && stat_reg[1] && !hwdata_i[1] |=> stat_reg[1])
    else $error("write of zero disturbed a wake flag");
  a_set_wins: assert property (
    s_clear_write(3) and flag_set[3] |=> stat_reg[3])
    else $error("wake event lost to same-cycle clear");
  a_amp_flag: assert property (
    $rose(sync2_reg[wmp_pkg::SRC_AMP_POS]) && wen_hi_reg[wmp_pkg::SRC_AMP_POS]
    |=> stat_reg[wmp_pkg::SRC_AMP_POS] && wake_request_o)
    else $error("amp-hour wake not recorded");
  a_curr_flag: assert property (
    src_rise[wmp_pkg::SRC_CURR_POS] && wen_hi_reg[wmp_pkg::SRC_CURR_POS]
    |=> stat_reg[wmp_pkg::SRC_CURR_POS])
    else $error("current threshold wake not recorded");
  a_cal_flag: assert property (
    src_rise[wmp_pkg::SRC_CAL_POS] && wen_hi_reg[wmp_pkg::SRC_CAL_POS]
    |=> stat_reg[wmp_pkg::SRC_CAL_POS])
    else $error("calibration wake not recorded");
  a_lin_flag: assert property (
    src_rise[wmp_pkg::SRC_LIN_POS] && wen_hi_reg[wmp_pkg::SRC_LIN_POS]
    |=> stat_reg[wmp_pkg::SRC_LIN_POS])
    else $error("LIN wake not recorded");
  a_pin_disabled: assert property (
    !stat_reg[0] && !wen_hi_reg[0] && !wr_stat |=> !stat_reg[0])
    else $error("disabled pin source set its flag");
  a_ms_divider_value_byte: assert property (
    wr_go && idx_reg == wmp_pkg::IDX_MS_DIVIDER_VALUE && size_reg == wmp_pkg::HSIZE_BYTE
    |=> $stable(ms_divider_value_reg))
    else $error("byte write reached the ms prescaler");
  a_slow_on_fast: assert property (
    derived_slow_clock_o |-> derived_fast_clock_o)
    else $error("slow clock pulse without fast pulse");
  a_fast_spacing: assert property (
    derived_fast_clock_o && ms_divider_value_reg > 16'h0002 && !wr_ms_divider_value |=> !derived_fast_clock_o[*2])
    else $error("fast pulses closer than prescaler allows");
  a_enl_zero: assert property (
    wen_lo_reg[6:0] == 7'h00)
    else $error("low enable reserved bits not zero");
  a_ready_drop: assert property (
    restart |=> !calib_sync_ready_o ##1 !calib_sync_ready_o)
    else $error("ready stayed high after restart");
  a_ready_set: assert property (
    meas_end |=> calib_sync_ready_o && calib_reg == $past(meas_val))
    else $error("sync finished without ready and new divider");
  a_trim_ro: assert property (
    wr_go && (idx_reg == wmp_pkg::IDX_TRIM_HI || idx_reg == wmp_pkg::IDX_TRIM_LO)
    && !meas_end |=> $stable(calib_reg))
    else $error("write altered trim value");
  a_calib_reset: assert property (
    $fell(srst_i) |-> calib_reg == wmp_pkg::CALIB_RST && !calib_sync_ready_o)
    else $error("calibrated divider not at reset value");

endmodule

`default_nettype wire

//--- common/wmp_pkg.sv
// Purpose: shared constants and types for the wake-up and ms prescaler register slice
// Assumes: AHB-Lite slave with 32-bit data, one register per aligned word
// Notes: byte address of a register is four times its index
`default_nettype none

package wmp_pkg;

  // ==========================================================================
  // address decode
  localparam logic [23:0] BASE_BLOCK_PAGE = 24'h000002;
  localparam logic [23:0] BASE_NONBLK_PAGE = 24'h000003;
  localparam logic [5:0] IDX_STAT_LO = 6'h03;
  localparam logic [5:0] IDX_MS_DIVIDER_VALUE = 6'h04;
  localparam logic [5:0] IDX_WEN_HI = 6'h06;
  localparam logic [5:0] IDX_WEN_LO = 6'h07;
  localparam logic [5:0] IDX_TRIM_HI = 6'h0E;
  localparam logic [5:0] IDX_TRIM_LO = 6'h0F;
  localparam logic [5:0] IDX_CTRL = 6'h10;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h12;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;

  // ==========================================================================
  // field positions
  localparam int unsigned SRC_AMP_POS = 7;
  localparam int unsigned SRC_CURR_POS = 6;
  localparam int unsigned SRC_CAL_POS = 5;
  localparam int unsigned SRC_LIN_POS = 4;
  localparam int unsigned WEN_LO_LTC_POS = 7;
  localparam int unsigned TRIM_HI_READY_POS = 7;
  localparam int unsigned IRQ_WAKE_POS = 0;
  localparam int unsigned IRQ_READY_POS = 1;

  // ==========================================================================
  // reset values and calibration count limit
  localparam logic [15:0] MS_DIVIDER_VALUE_RST = 16'h7D00;
  localparam logic [12:0] CALIB_RST = 13'h0200;
  localparam logic [12:0] CALIB_MAX = 13'h1FFF;
  localparam logic [7:0] STAT_LO_RST = 8'h00;
  localparam logic [7:0] WEN_HI_RST = 8'h00;
  localparam logic [7:0] WEN_LO_RST = 8'h00;
  localparam logic [1:0] PF_RST = 2'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // ==========================================================================
  // calibration sequence
  typedef enum logic [1:0] {
    WMP_SYNC_START = 2'h0,
    WMP_SYNC_MEASURE = 2'h1,
    WMP_SYNC_DONE = 2'h3
  } wmp_sync_type;

endpackage

`default_nettype wire

//--- sim/wmp_ahb_master.sv
// Purpose: bus master model of the controlling die
// Assumes: single transfers of the size passed to xfer, one at a time
// Notes: outputs change by non-blocking assignment just after a rising edge
`default_nettype none

module wmp_ahb_master (
  input wire logic clock_i,
  input wire logic hready_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end

  // ==========================================================================
  // one transfer: address phase, then data phase, each held until hready
  task automatic xfer(input logic wr, input logic pg, input logic [5:0] idx,
                      input logic [2:0] sz, input logic [31:0] wd);
    hsel_o <= 1'b1;
    htrans_o <= 2'h2;
    haddr_o <= {pg ? wmp_pkg::BASE_NONBLK_PAGE : wmp_pkg::BASE_BLOCK_PAGE, idx, 2'h0};
    hwrite_o <= wr;
    hsize_o <= sz;
    @(posedge clock_i);
    while (hready_i !== 1'b1) @(posedge clock_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= wd;
    @(posedge clock_i);
    while (hready_i !== 1'b1) @(posedge clock_i);
    // released data lines do not keep the last value
    hwdata_o <= ~wd;
  endtask
endmodule

`default_nettype wire

//--- sim/wmp_regs_tb.sv
// Purpose: self-checking bench for the wake-up and ms prescaler registers
// Assumes: lp oscillator rises every 4 clocks
// Notes: reads are checked by a bus monitor against a queue of notes
`default_nettype none

module wmp_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel, hwrite, hready, hresp, fast, slow, cal_clk, ready, irq, wake;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] wsrc = 8'h00;
  logic ltc = 1'b0;
  logic rd_ph = 1'b0;
  logic [1:0] lpc = 2'h0;
  int fail_count = 0;
  int tests_run = 0;
  int wakes = 0;
  logic [31:0] exp_q[$];
  string name_q[$];

  wmp_ahb_master u_ahb_master (.clock_i(clock_i), .hready_i(hready), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));

  wmp_regs u_wmp_regs (.clock_i(clock_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .wake_source_i(wsrc), .lifetime_overflow_i(ltc), .lp_osc_i(lpc[1]),
    .wake_request_o(wake), .derived_fast_clock_o(fast), .derived_slow_clock_o(slow),
    .calibrated_low_freq_clock_o(cal_clk), .calib_sync_ready_o(ready), .irq_o(irq));

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) lpc <= lpc + 2'h1;

  // ==========================================================================
  // monitor: read data against the oldest note, wake pulses counted
  always @(posedge clock_i) begin
    if (rd_ph && hready === 1'b1) begin
      check(name_q.pop_front(), exp_q.pop_front(), hrdata);
      check_bit("hresp", 1'b0, hresp);
    end
    if (hsel && htrans[1] && hready) rd_ph <= !hwrite;
    else if (hready) rd_ph <= 1'b0;
    if (wake === 1'b1) wakes++;
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic check_bit(input string nm, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", nm, e, s);
    end
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return fast;
      1: return slow;
      2: return cal_clk;
      3: return ready;
      default: return irq;
    endcase
  endfunction

  task automatic rd(input string nm, input logic [5:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    name_q.push_back(nm);
    u_ahb_master.xfer(1'b0, 1'b0, idx, 3'h2, 32'h0);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    u_ahb_master.xfer(1'b1, 1'b0, idx, 3'h2, d);
  endtask

  task automatic chk_lvl(input string nm, input logic e, input int k);
    repeat (2) @(posedge clock_i);
    #1;
    check_bit(nm, e, pick(k));
    @(posedge clock_i);
  endtask

  // cycles between two pulses of the chosen output
  task automatic gap(input int k, output int n);
    n = 0;
    do @(posedge clock_i); while (pick(k) !== 1'b1);
    do begin
      @(posedge clock_i);
      n++;
    end while (pick(k) !== 1'b1);
  endtask

  task automatic pulse(input logic [8:0] v);
    {ltc, wsrc} <= v;
    repeat (3) @(posedge clock_i);
    {ltc, wsrc} <= 9'h000;
    repeat (5) @(posedge clock_i);
  endtask

  task automatic stop_test();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    stop_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    int n;
    int w0;
    logic [15:0] p;
    logic [7:0] en;
    void'($urandom(83808));
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    rd("ms_divider_value", wmp_pkg::IDX_MS_DIVIDER_VALUE, 32'h0000_7D00);
    rd("trim_hi", wmp_pkg::IDX_TRIM_HI, 32'h0000_0002);
    rd("trim_lo", wmp_pkg::IDX_TRIM_LO, 32'h0000_0000);
    rd("wen_lo", wmp_pkg::IDX_WEN_LO, 32'h0000_0000);
    u_ahb_master.xfer(1'b1, 1'b0, wmp_pkg::IDX_MS_DIVIDER_VALUE, wmp_pkg::HSIZE_BYTE, 32'h11);
    wr(wmp_pkg::IDX_TRIM_HI, 32'h0000_00FF);
    wr(wmp_pkg::IDX_TRIM_LO, 32'h0000_00FF);
    rd("ms_divider_value", wmp_pkg::IDX_MS_DIVIDER_VALUE, 32'h0000_7D00);
    rd("trim_hi", wmp_pkg::IDX_TRIM_HI, 32'h0000_0002);
    rd("trim_lo", wmp_pkg::IDX_TRIM_LO, 32'h0000_0000);
    rd("unmapped", 6'h3F, 32'h0000_0000);
    p = 16'h0008 + 16'($urandom_range(15));
    u_ahb_master.xfer(1'b1, 1'b1, wmp_pkg::IDX_MS_DIVIDER_VALUE, 3'h2, {16'h0000, p});
    rd("ms_divider_value", wmp_pkg::IDX_MS_DIVIDER_VALUE, {16'h0000, p});
    chk_lvl("ready", 1'b0, 3);
    gap(0, n);
    check("fast_gap", {16'h0000, p}, 32'(n));
    for (int c = 0; c < 4; c++) begin
      wr(wmp_pkg::IDX_CTRL, 32'(c));
      gap(1, n);
      n = 0;
      do begin
        @(posedge clock_i);
        n += int'(fast === 1'b1);
      end while (slow !== 1'b1);
      check("slow_div", 32'(1 << c), 32'(n));
    end
    wr(wmp_pkg::IDX_CTRL, 32'h0);
    wr(wmp_pkg::IDX_IRQ_MASK, 32'h0000_0002);
    wr(wmp_pkg::IDX_MS_DIVIDER_VALUE, 32'h0000_0028);
    chk_lvl("ready", 1'b0, 3);
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(posedge clock_i);
      n++;
    end
    chk_lvl("ready", 1'b1, 3);
    chk_lvl("irq", 1'b1, 4);
    rd("trim_hi", wmp_pkg::IDX_TRIM_HI, 32'h0000_0080);
    rd("trim_lo", wmp_pkg::IDX_TRIM_LO, 32'h0000_000A);
    gap(2, n);
    check("cal_gap", 32'h0000_0028, 32'(n));
    wr(wmp_pkg::IDX_TRIM_LO, 32'h0000_00FF);
    rd("trim_lo", wmp_pkg::IDX_TRIM_LO, 32'h0000_000A);
    wr(wmp_pkg::IDX_IRQ_MASK, 32'h0);
    chk_lvl("irq", 1'b0, 4);
    wr(wmp_pkg::IDX_IRQ_MASK, 32'h0000_0002);
    chk_lvl("irq", 1'b1, 4);
    wr(wmp_pkg::IDX_IRQ_STAT, 32'h0000_0003);
    chk_lvl("irq", 1'b0, 4);
    wr(wmp_pkg::IDX_WEN_HI, 32'h0000_00FF);
    for (int b = 0; b < 8; b++) begin
      w0 = wakes;
      pulse(9'(1 << b));
      rd("flags", wmp_pkg::IDX_STAT_LO, 32'(1 << b));
      check("wakes", 32'(w0 + 1), 32'(wakes));
      wr(wmp_pkg::IDX_STAT_LO, {24'h0, ~8'(1 << b)});
      rd("flags", wmp_pkg::IDX_STAT_LO, 32'(1 << b));
      wr(wmp_pkg::IDX_STAT_LO, 32'(1 << b));
      rd("flags", wmp_pkg::IDX_STAT_LO, 32'h0);
    end
    // pin 3 event lands in the data phase of a clear of the same flag
    wsrc[3] <= 1'b1;
    @(posedge clock_i);
    wr(wmp_pkg::IDX_STAT_LO, 32'h0000_0008);
    wsrc[3] <= 1'b0;
    rd("flags", wmp_pkg::IDX_STAT_LO, 32'h0000_0008);
    wr(wmp_pkg::IDX_STAT_LO, 32'h0000_0008);
    rd("flags", wmp_pkg::IDX_STAT_LO, 32'h0);
    en = 8'($urandom);
    wr(wmp_pkg::IDX_WEN_HI, {24'h0, en});
    rd("wen_hi", wmp_pkg::IDX_WEN_HI, {24'h0, en});
    w0 = wakes;
    pulse(9'h0FF);
    rd("flags", wmp_pkg::IDX_STAT_LO, {24'h0, en});
    check("wakes", 32'(w0 + int'(en != 8'h00)), 32'(wakes));
    wr(wmp_pkg::IDX_STAT_LO, 32'h0000_00FF);
    wr(wmp_pkg::IDX_WEN_LO, 32'h0000_00FF);
    rd("wen_lo", wmp_pkg::IDX_WEN_LO, 32'h0000_0080);
    w0 = wakes;
    pulse(9'h100);
    check("wakes", 32'(w0 + 1), 32'(wakes));
    wr(wmp_pkg::IDX_WEN_LO, 32'h0);
    w0 = wakes;
    pulse(9'h100);
    check("wakes", 32'(w0), 32'(wakes));
    stop_test();
  end
endmodule

`default_nettype wire
